// >>> hw/ppc_pkg.sv
// shared types and constants for the parallel port pin polarity control
package ppc_pkg;

   // register byte offsets
   localparam logic [7:0] PPC_CTRL_OFS = 8'h00;
   localparam logic [7:0] PPC_MODE_OFS = 8'h04;
   localparam logic [7:0] PPC_STAT_OFS = 8'h08;

   // control field positions
   localparam int PPC_CTL_PTE = 8;
   localparam int PPC_CTL_SFN = 6;
   localparam int PPC_CTL_LAT = 5;
   localparam int PPC_CTL_S2P = 4;
   localparam int PPC_CTL_S1P = 3;
   localparam int PPC_CTL_GAP = 2;
   localparam int PPC_CTL_WRP = 1;
   localparam int PPC_CTL_RDP = 0;

   // reset values and write masks
   localparam logic [8:0] PPC_CTRL_RST = 9'h000;
   localparam logic [8:0] PPC_CTRL_WMASK = 9'h1FB;
   localparam logic [1:0] PPC_MODE_RST = 2'h0;
   localparam logic [5:0] PPC_PIN_RST = 6'h3F;
   localparam logic [1:0] PPC_OE_N_RST = 2'h3;

   // mode and select function codes
   localparam logic [1:0] PPC_MODE_MASTER1 = 2'h3;
   localparam logic [1:0] PPC_SFN_ADDR = 2'h0;
   localparam logic [1:0] PPC_SFN_ONE = 2'h1;
   localparam logic [1:0] PPC_SFN_BOTH = 2'h2;

   // pin vector positions
   localparam int PPC_PIN_W = 6;
   localparam int PPC_PIN_RD = 0;
   localparam int PPC_PIN_WR = 1;
   localparam int PPC_PIN_S1 = 2;
   localparam int PPC_PIN_S2 = 3;
   localparam int PPC_PIN_LL = 4;
   localparam int PPC_PIN_LH = 5;

   typedef struct packed {
      logic strobe_port_enable;
      logic [1:0] select_function_field;
      logic latch_polarity;
      logic select_two_polarity;
      logic select_one_polarity;
      logic gap;
      logic write_strobe_polarity;
      logic read_strobe_polarity;
   } ppc_ctl_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic enb;
      logic rdwr;
      logic latch_low;
      logic latch_high;
      logic sel1;
      logic sel2;
   } ppc_strobe_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ppc_wb_req_t;

   typedef enum logic [1:0] {
      PPC_ST_IDLE = 2'b01,
      PPC_ST_ACK = 2'b10
   } ppc_bus_st_t;

endpackage : ppc_pkg

// >>> hw/ppc_select_map.sv
// maps the two select pins onto selects or high address bits
module ppc_select_map (
   input wire logic [1:0] func_i,
   input wire logic sel1_i,
   input wire logic sel2_i,
   input wire logic pol1_i,
   input wire logic pol2_i,
   input wire logic [1:0] addr_hi_i,
   output logic [1:0] act_o,
   output logic [1:0] pol_o
);
   import ppc_pkg::*;

   always_comb begin
      act_o = {sel2_i, sel1_i};
      pol_o = {pol2_i, pol1_i};
      case (func_i)
         PPC_SFN_ADDR: begin
            act_o = addr_hi_i;
            pol_o = 2'b11;
         end
         PPC_SFN_ONE: begin
            act_o[0] = addr_hi_i[0];
            pol_o[0] = 1'b1;
         end
         default: begin
            act_o = {sel2_i, sel1_i};
         end
      endcase
   end

endmodule : ppc_select_map

// >>> hw/ppc_pin_drive.sv
// registered pin drivers with per-pin polarity inversion
module ppc_pin_drive (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:0] act_i,
   input wire logic [5:0] pol_i,
   output logic [5:0] pin_o
);
   import ppc_pkg::*;

   genvar k;
   generate
      for (k = 0; k < PPC_PIN_W; k++) begin : g_pin
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               pin_o[k] <= PPC_PIN_RST[k];
            end else begin
               pin_o[k] <= act_i[k] ^ ~pol_i[k];
            end
         end
      end
   endgenerate

endmodule : ppc_pin_drive

// >>> hw/ppc_port_ctrl.sv
// parallel port control register, strobe pin enable and polarity logic
//
// Contract
// - strobe enable bit on drives read and write pins; off disables them.
// - select code 10 uses both select pins as selects; 11 reserved.
// - select code 01 gives address bit 14 on pin one, select on two.
// - select code 00 gives address bits 14 and 15 on pins one, two.
// - latch polarity bit sets both address latch strobes high or low active.
// - second select polarity bit sets its output active level.
// - first select polarity bit sets its output active level.
// - outside master mode 1 write polarity bit sets write strobe level.
// - in master mode 1 write polarity bit sets enable strobe level.
// - outside master mode 1 read polarity bit sets read strobe level.
// - in master mode 1 read polarity bit sets direction strobe level.
// - select polarity has no effect on pins used as address lines.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
module ppc_port_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ppc_pkg::ppc_wb_req_t wb_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire ppc_pkg::ppc_strobe_t strobe_i,
   input wire logic [1:0] addr_hi_i,
   output logic read_strobe_pin_o,
   output logic read_strobe_pin_oe_n_o,
   output logic write_strobe_pin_o,
   output logic write_strobe_pin_oe_n_o,
   output logic select_one_pin_o,
   output logic select_two_pin_o,
   output logic low_address_latch_o,
   output logic high_address_latch_o
);
   import ppc_pkg::*;

   ppc_ctl_t ctl_reg;
   logic [1:0] mode_reg;
   ppc_bus_st_t st_reg;
   ppc_bus_st_t st_next;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;
   logic [1:0] oe_n_reg;
   logic live_reg;
   logic req;
   logic wr_hit;
   logic master1;
   logic [8:0] ctl_next;
   logic [1:0] sel_act;
   logic [1:0] sel_pol;
   logic [5:0] act;
   logic [5:0] pol;
   logic [5:0] pin;

   assign req = wb_i.cyc & wb_i.stb;
   assign wr_hit = req & wb_i.we & (st_reg == PPC_ST_IDLE);
   assign master1 = (mode_reg == PPC_MODE_MASTER1);

   // bus state machine
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         PPC_ST_IDLE: begin
            if (req) begin
               st_next = PPC_ST_ACK;
            end
         end
         PPC_ST_ACK: begin
            st_next = PPC_ST_IDLE;
         end
         default: begin
            st_next = PPC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= PPC_ST_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // one-cycle acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= req & (st_reg == PPC_ST_IDLE);
      end
   end

   // control register write with byte lanes
   always_comb begin
      ctl_next = ctl_reg;
      if (wb_i.sel[0]) begin
         ctl_next[7:0] = wb_i.dat[7:0];
      end
      if (wb_i.sel[1]) begin
         ctl_next[8] = wb_i.dat[8];
      end
      ctl_next = ctl_next & PPC_CTRL_WMASK;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_reg <= PPC_CTRL_RST;
      end else if (wr_hit && wb_i.adr == PPC_CTRL_OFS) begin
         ctl_reg <= ctl_next;
      end
   end

   // mode register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= PPC_MODE_RST;
      end else if (wr_hit && wb_i.adr == PPC_MODE_OFS && wb_i.sel[0]) begin
         mode_reg <= wb_i.dat[1:0];
      end
   end

   // read data mux, unmapped reads zero
   always_comb begin
      dat_next = 32'h0000_0000;
      case (wb_i.adr)
         PPC_CTRL_OFS: begin
            dat_next[8:0] = ctl_reg;
         end
         PPC_MODE_OFS: begin
            dat_next[1:0] = mode_reg;
         end
         PPC_STAT_OFS: begin
            dat_next[5:0] = pin;
            dat_next[9:8] = oe_n_reg;
         end
         default: begin
            dat_next = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= 32'h0000_0000;
      end else if (req && !wb_i.we && st_reg == PPC_ST_IDLE) begin
         dat_reg <= dat_next;
      end else begin
         dat_reg <= 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_n_reg <= PPC_OE_N_RST;
      end else begin
         oe_n_reg <= {2{~ctl_reg.strobe_port_enable}};
      end
   end

   ppc_select_map u_map (
      .func_i(ctl_reg.select_function_field),
      .sel1_i(strobe_i.sel1),
      .sel2_i(strobe_i.sel2),
      .pol1_i(ctl_reg.select_one_polarity),
      .pol2_i(ctl_reg.select_two_polarity),
      .addr_hi_i(addr_hi_i),
      .act_o(sel_act),
      .pol_o(sel_pol)
   );

   // active-high pin sources
   always_comb begin
      act = '0;
      act[PPC_PIN_WR] = master1 ? strobe_i.enb : strobe_i.wr;
      act[PPC_PIN_RD] = master1 ? strobe_i.rdwr : strobe_i.rd;
      if (!ctl_reg.strobe_port_enable) begin
         act[PPC_PIN_WR] = 1'b0;
         act[PPC_PIN_RD] = 1'b0;
      end
      act[PPC_PIN_S1] = sel_act[0];
      act[PPC_PIN_S2] = sel_act[1];
      act[PPC_PIN_LL] = strobe_i.latch_low;
      act[PPC_PIN_LH] = strobe_i.latch_high;
   end

   // polarity vector
   always_comb begin
      pol = '0;
      pol[PPC_PIN_RD] = ctl_reg.read_strobe_polarity;
      pol[PPC_PIN_WR] = ctl_reg.write_strobe_polarity;
      pol[PPC_PIN_S1] = sel_pol[0];
      pol[PPC_PIN_S2] = sel_pol[1];
      pol[PPC_PIN_LL] = ctl_reg.latch_polarity;
      pol[PPC_PIN_LH] = ctl_reg.latch_polarity;
   end

   ppc_pin_drive u_drive (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .act_i(act),
      .pol_i(pol),
      .pin_o(pin)
   );

   assign read_strobe_pin_o = pin[PPC_PIN_RD];
   assign write_strobe_pin_o = pin[PPC_PIN_WR];
   assign select_one_pin_o = pin[PPC_PIN_S1];
   assign select_two_pin_o = pin[PPC_PIN_S2];
   assign low_address_latch_o = pin[PPC_PIN_LL];
   assign high_address_latch_o = pin[PPC_PIN_LH];
   assign read_strobe_pin_oe_n_o = oe_n_reg[0];
   assign write_strobe_pin_oe_n_o = oe_n_reg[1];

   // checks, valid one cycle after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         live_reg <= 1'b0;
      end else begin
         live_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_strobe_en;
      live_reg |-> read_strobe_pin_oe_n_o == !$past(ctl_reg.strobe_port_enable)
         && write_strobe_pin_oe_n_o == read_strobe_pin_oe_n_o;
   endproperty
   a_strobe_en: assert property (p_strobe_en) else $error("strobe enable wrong");

   property p_cs_both;
      live_reg && $past(ctl_reg.select_function_field[1]) |->
         select_two_pin_o == ($past(strobe_i.sel2) ^ !$past(ctl_reg.select_two_polarity));
   endproperty
   a_cs_both: assert property (p_cs_both) else $error("select two level wrong");

   property p_cs_one;
      live_reg && $past(ctl_reg.select_function_field) == PPC_SFN_ONE |->
         select_one_pin_o == $past(addr_hi_i[0])
         && select_two_pin_o == ($past(strobe_i.sel2) ^ !$past(ctl_reg.select_two_polarity));
   endproperty
   a_cs_one: assert property (p_cs_one) else $error("code 01 mapping wrong");

   property p_cs_addr;
      live_reg && $past(ctl_reg.select_function_field) == PPC_SFN_ADDR |->
         {select_two_pin_o, select_one_pin_o} == $past(addr_hi_i);
   endproperty
   a_cs_addr: assert property (p_cs_addr) else $error("address mapping wrong");

   property p_latch;
      live_reg |-> low_address_latch_o == ($past(strobe_i.latch_low) ^ !$past(ctl_reg.latch_polarity))
         && high_address_latch_o == ($past(strobe_i.latch_high) ^ !$past(ctl_reg.latch_polarity));
   endproperty
   a_latch: assert property (p_latch) else $error("latch polarity wrong");

   property p_cs1_pol;
      live_reg && $past(ctl_reg.select_function_field[1]) |->
         select_one_pin_o == ($past(strobe_i.sel1) ^ !$past(ctl_reg.select_one_polarity));
   endproperty
   a_cs1_pol: assert property (p_cs1_pol) else $error("select one level wrong");

   property p_wr_pol;
      live_reg && $past(ctl_reg.strobe_port_enable) |->
         write_strobe_pin_o == (($past(master1) ? $past(strobe_i.enb) : $past(strobe_i.wr))
         ^ !$past(ctl_reg.write_strobe_polarity));
   endproperty
   a_wr_pol: assert property (p_wr_pol) else $error("write pin level wrong");

   property p_rd_pol;
      live_reg && $past(ctl_reg.strobe_port_enable) |->
         read_strobe_pin_o == (($past(master1) ? $past(strobe_i.rdwr) : $past(strobe_i.rd))
         ^ !$past(ctl_reg.read_strobe_polarity));
   endproperty
   a_rd_pol: assert property (p_rd_pol) else $error("read pin level wrong");

   property p_gap;
      ack_reg && $past(wb_i.adr) == PPC_CTRL_OFS |-> wb_dat_o[PPC_CTL_GAP] == 1'b0;
   endproperty
   a_gap: assert property (p_gap) else $error("gap bit reads one");

   property p_ack;
      req && st_reg == PPC_ST_IDLE |=> ack_reg ##1 !ack_reg;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");

endmodule : ppc_port_ctrl

// >>> testbench/ppc_pin_peer.sv
// far-side peripheral model sampling the port pins
module ppc_pin_peer (
   input wire logic clk_i,
   input wire logic rd_i,
   input wire logic rd_oe_n_i,
   input wire logic wr_i,
   input wire logic wr_oe_n_i,
   input wire logic s1_i,
   input wire logic s2_i,
   input wire logic ll_i,
   input wire logic lh_i,
   output logic [7:0] seen_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins taken once a cycle, as an external device would latch them
   always_ff @(posedge clk_i) begin
      seen_o <= {wr_oe_n_i, rd_oe_n_i, lh_i, ll_i, s2_i, s1_i, wr_i, rd_i};
   end
endmodule : ppc_pin_peer

// >>> testbench/tb_top.sv
// self-checking bench for the port control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ppc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   ppc_wb_req_t wb = '0;
   ppc_strobe_t strobe = '0;
   logic [1:0] addr_hi = 2'h0;
   logic ack;
   logic [31:0] rdat;
   logic rd, rd_oe_n, wr, wr_oe_n, s1, s2, ll, lh;
   logic [7:0] seen;
   logic [31:0] q;
   logic [7:0] p;
   int fails = 0;
   int samples_checked = 0;
   logic [8:0] ctl_tab [6] = '{9'h000, 9'h1FB, 9'h100, 9'h149, 9'h1B2, 9'h0C9};
   logic [7:0] stb_tab [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};

   ppc_port_ctrl u_ppc_port_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(ack),
      .wb_dat_o(rdat), .strobe_i(strobe), .addr_hi_i(addr_hi), .read_strobe_pin_o(rd),
      .read_strobe_pin_oe_n_o(rd_oe_n), .write_strobe_pin_o(wr),
      .write_strobe_pin_oe_n_o(wr_oe_n), .select_one_pin_o(s1), .select_two_pin_o(s2),
      .low_address_latch_o(ll), .high_address_latch_o(lh));
   ppc_pin_peer u_ppc_pin_peer (.clk_i(clk_i), .rd_i(rd), .rd_oe_n_i(rd_oe_n), .wr_i(wr),
      .wr_oe_n_i(wr_oe_n), .s1_i(s1), .s2_i(s2), .ll_i(ll), .lh_i(lh), .seen_o(seen));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   task automatic end_of_test();
      if (fails == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // one classic cycle, held until ack is sampled high
   task automatic wb_acc(input logic we, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         fails++;
         end_of_test();
      end else begin
         r = rdat;
         wb <= '0;
      end
   endtask : wb_acc

   // expected {wr_oe_n, rd_oe_n, lh, ll, s2, s1, wr, rd}
   function automatic logic [7:0] exp_pins(logic [8:0] c, logic [1:0] m, logic [7:0] s);
      logic rs, ws;
      logic [7:0] e;
      rs = (m == 2'h3) ? s[4] : s[7];
      ws = (m == 2'h3) ? s[5] : s[6];
      e[0] = (c[8] & rs) ^ ~c[0];
      e[1] = (c[8] & ws) ^ ~c[1];
      e[2] = (c[7:6] < 2'h2) ? ~s[0] : s[1] ^ ~c[3];
      e[3] = (c[7:6] == 2'h0) ? ~s[1] : s[0] ^ ~c[4];
      e[4] = s[3] ^ ~c[5];
      e[5] = s[2] ^ ~c[5];
      e[6] = ~c[8];
      e[7] = ~c[8];
      return e;
   endfunction : exp_pins

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb_acc(1'b0, PPC_CTRL_OFS, 4'hF, 32'h0, q);
      chk(q, 32'h0);
      wb_acc(1'b0, PPC_MODE_OFS, 4'hF, 32'h0, q);
      chk(q, 32'h0);
      // gap bit stays zero
      wb_acc(1'b1, PPC_CTRL_OFS, 4'hF, 32'hFFFF_FFFF, q);
      wb_acc(1'b0, PPC_CTRL_OFS, 4'hF, 32'h0, q);
      chk(q, 32'h0000_01FB);
      // lane one untouched by a low-lane write
      wb_acc(1'b1, PPC_CTRL_OFS, 4'h1, 32'h0000_0000, q);
      wb_acc(1'b0, PPC_CTRL_OFS, 4'hF, 32'h0, q);
      chk(q, 32'h0000_0100);
      wb_acc(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF, q);
      wb_acc(1'b0, 8'h0C, 4'hF, 32'h0, q);
      chk(q, 32'h0);
      wb_acc(1'b1, PPC_STAT_OFS, 4'hF, 32'hFFFF_FFFF, q);
      // all four modes, each tabled control value and strobe pattern checked at the pins and in the status register
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 6; c++) begin
            wb_acc(1'b1, PPC_MODE_OFS, 4'hF, 32'(m), q);
            wb_acc(1'b1, PPC_CTRL_OFS, 4'h3, {23'h0, ctl_tab[c]}, q);
            wb_acc(1'b0, PPC_MODE_OFS, 4'hF, 32'h0, q);
            chk(q, 32'(m));
            for (int s = 0; s < 4; s++) begin
               @(posedge clk_i);
               strobe <= ppc_strobe_t'(stb_tab[s]);
               addr_hi <= ~stb_tab[s][1:0];
               repeat (3) @(posedge clk_i);
               p = exp_pins(ctl_tab[c], 2'(m), stb_tab[s]);
               // pin levels and enables
               chk({24'h0, seen}, {24'h0, p});
               wb_acc(1'b0, PPC_STAT_OFS, 4'hF, 32'h0, q);
               chk(q, {22'h0, p[7:6], 2'h0, p[5:0]});
            end
         end
      end
      end_of_test();
   end
endmodule : tb_top
